// *** ciap_map.svh ***
// Register map constants for the indirect register access port
`ifndef CIAP_MAP_SVH
`define CIAP_MAP_SVH
`define CIAP_IDX_W          2
`define CIAP_IDX_CTRL       2'h0
`define CIAP_IDX_RESET      2'h0
`define CIAP_BIT_HALT       0
`define CIAP_BIT_INIT       1
`define CIAP_BIT_START      2
`define CIAP_BIT_INTEN      6
`define CIAP_BIT_INTR       7
`define CIAP_BIT_TXTO       14
`define CIAP_BIT_ERR        15
`define CIAP_TXTO_BYTES     11'h5ef
`define CIAP_CSR_RESET      16'h0001
`define CIAP_ZERO16         16'h0000
`endif

// *** ciap_pkg.sv ***
// Types for the indirect register access port
`default_nettype none
package ciap_pkg;
   typedef struct packed {
      logic        sel_index;
      logic        wr;
      logic [15:0] wdata;
   } ciap_req_t;
   typedef enum logic [2:0] {
      CIAP_IDLE  = 3'b001,
      CIAP_FETCH = 3'b010,
      CIAP_RUN   = 3'b100
   } ciap_state_t;
endpackage
`default_nettype wire

// *** ciap_regfile.sv ***
// Three-entry register store for the halt-only control registers
`include "ciap_map.svh"
`default_nettype none
module ciap_regfile #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 3
) (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   // Access
   input  wire logic                     we,
   input  wire logic [1:0]               addr,
   input  wire logic [WIDTH-1:0]         wdata,
   output var  logic [WIDTH-1:0]         rdata_q
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++)
      begin : g_ent
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
               mem_q[i] <= '0;
            else if (we && (addr == 2'(i + 1)))
               mem_q[i] <= wdata;
         end
      end
   endgenerate

   // Registered read port
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= '0;
      else if (addr != `CIAP_IDX_CTRL)
         rdata_q <= mem_q[addr - 2'h1];
      else
         rdata_q <= '0;
   end
endmodule
`default_nettype wire

// *** ciap_top.sv ***
// Indirect control/status register access port with transmit timeout flag
// Behaviour
// R01 - Four registers, reached only indirectly
// R02 - Write index, then access data port
// R03 - Index holds until next index write
// R04 - Select low data, high index
// R05 - Sixteen-bit data port reads/writes selected register
// R06 - Registers one-three only while halted
// R07 - Not halted: ready, read undefined, write dropped
// R08 - Host places twelve-word init block
// R09 - Separate rings, four-word quad-aligned entries
// R10 - Buffers may start at any byte
// R11 - Init block fetched before rings
// R12 - Flag transmitter on channel too long
// R13 - Flag after 1519 bytes, interrupt if enabled
// R14 - Index bits 15:2 read zero
// R15 - Reset clears index to zero
`include "ciap_map.svh"
`default_nettype none
module ciap_top (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Slave access port
   input  wire logic              cs,
   input  wire logic              port_sel,
   input  wire logic              rd,
   input  wire logic [15:0]       dal_in,
   output var  logic [15:0]       dal_out_q,
   output logic                   dal_oe,
   output logic                   ready,
   // Engine events
   input  wire logic              init_done,
   input  wire logic              tx_byte,
   input  wire logic              tx_frame_end,
   // Engine control and status
   output logic                   halted,
   output logic                   fetch_init,
   output logic                   ring_access,
   output logic                   irq
);
   ciap_pkg::ciap_req_t   req;
   ciap_pkg::ciap_state_t state_q;
   logic [`CIAP_IDX_W-1:0] idx_q;
   logic [15:0]           ctrl_q;
   logic [10:0]           txcnt_q;
   logic [15:0]           rf_rdata;
   logic                  acc_q;
   logic                  data_wr;
   logic                  ctrl_wr;
   logic                  rf_ok;
   logic                  txto_set;

   assign req.sel_index = port_sel;
   assign req.wr        = cs & ~rd;
   assign req.wdata     = dal_in;

   // One-cycle ready per access
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         acc_q <= 1'b0;
      else
         acc_q <= cs & ~acc_q;
   end
   assign ready  = acc_q;             // see R07
   assign dal_oe = acc_q & rd;

   assign data_wr = req.wr && !acc_q && !req.sel_index;       // see R04
   assign ctrl_wr = data_wr && (idx_q == `CIAP_IDX_CTRL);
   assign rf_ok   = ctrl_q[`CIAP_BIT_HALT];                    // see R06

   // Index pointer
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         idx_q <= `CIAP_IDX_RESET;    // see R15
      else if (req.wr && !acc_q && req.sel_index)
         idx_q <= req.wdata[`CIAP_IDX_W-1:0];   // see R02 see R03
   end

   ciap_regfile #(.WIDTH(16), .DEPTH(3)) u_rf (   // see R01
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .we      (data_wr && (idx_q != `CIAP_IDX_CTRL) && rf_ok),  // see R07
      .addr    (idx_q),
      .wdata   (req.wdata),
      .rdata_q (rf_rdata)
   );

   // Transmit byte counter
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         txcnt_q <= '0;
      else if (tx_frame_end || ctrl_q[`CIAP_BIT_HALT])
         txcnt_q <= '0;
      else if (tx_byte && txcnt_q != `CIAP_TXTO_BYTES)
         txcnt_q <= txcnt_q + 11'h1;   // see R12 see R13
   end
   assign txto_set = tx_byte && (txcnt_q == `CIAP_TXTO_BYTES - 11'h1);  // see R12 see R13

   // Register zero: halt, init, start, interrupt enable, timeout flag
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_q <= `CIAP_CSR_RESET;
      else if (ctrl_wr && req.wdata[`CIAP_BIT_HALT])
         ctrl_q <= `CIAP_CSR_RESET;
      else
      begin
         if (ctrl_wr)
         begin
            if (req.wdata[`CIAP_BIT_INIT])
               ctrl_q[`CIAP_BIT_INIT] <= 1'b1;
            if (req.wdata[`CIAP_BIT_START])
               ctrl_q[`CIAP_BIT_START] <= 1'b1;
            if (req.wdata[`CIAP_BIT_INIT] || req.wdata[`CIAP_BIT_START])
               ctrl_q[`CIAP_BIT_HALT] <= 1'b0;
            ctrl_q[`CIAP_BIT_INTEN] <= req.wdata[`CIAP_BIT_INTEN];
         end
         // Set wins over write-one clear
         if (txto_set)
            ctrl_q[`CIAP_BIT_TXTO] <= 1'b1;                     // see R13
         else if (ctrl_wr && req.wdata[`CIAP_BIT_TXTO])
            ctrl_q[`CIAP_BIT_TXTO] <= 1'b0;
      end
   end

   // Init fetch precedes ring access
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= ciap_pkg::CIAP_IDLE;
      else if (ctrl_q[`CIAP_BIT_HALT])
         state_q <= ciap_pkg::CIAP_IDLE;
      else
         unique case (state_q)
            ciap_pkg::CIAP_IDLE:
               if (ctrl_q[`CIAP_BIT_INIT])
                  state_q <= ciap_pkg::CIAP_FETCH;
            ciap_pkg::CIAP_FETCH:
               if (init_done)
                  state_q <= ciap_pkg::CIAP_RUN;             // see R11
            ciap_pkg::CIAP_RUN:
               state_q <= ciap_pkg::CIAP_RUN;
            default:
               state_q <= ciap_pkg::CIAP_IDLE;
         endcase
   end

   assign halted      = ctrl_q[`CIAP_BIT_HALT];
   assign fetch_init  = (state_q == ciap_pkg::CIAP_FETCH);
   assign ring_access = (state_q == ciap_pkg::CIAP_RUN) && ctrl_q[`CIAP_BIT_START];  // see R09
   assign irq = ctrl_q[`CIAP_BIT_INTEN] & ctrl_q[`CIAP_BIT_TXTO];  // see R13

   // Read data
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         dal_out_q <= `CIAP_ZERO16;
      else if (cs && !acc_q)
      begin
         if (req.sel_index)
            dal_out_q <= {14'h0000, idx_q};                 // see R14
         else if (idx_q == `CIAP_IDX_CTRL)
            dal_out_q <= {ctrl_q[15], ctrl_q[14:8], irq, ctrl_q[6:0]} |
                         {ctrl_q[`CIAP_BIT_TXTO], 15'h0000};  // see R05
         else
            dal_out_q <= rf_ok ? rf_rdata : `CIAP_ZERO16;    // see R07
      end
   end

   property p_ready_one;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && !acc_q) |=> ready ##1 !ready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready not one cycle"); // see R07

   property p_idx_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      !(cs && !rd && port_sel && !acc_q) |=> $stable(idx_q);
   endproperty
   a_idx_hold: assert property (p_idx_hold) else $error("index changed"); // see R03

   property p_idx_load;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && !rd && port_sel && !acc_q) |=> idx_q == $past(dal_in[1:0]);
   endproperty
   a_idx_load: assert property (p_idx_load) else $error("index not loaded"); // see R02

   property p_idx_rd;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && rd && port_sel && !acc_q) |=> dal_out_q[15:2] == 14'h0000;
   endproperty
   a_idx_rd: assert property (p_idx_rd) else $error("reserved bits set"); // see R14

   property p_txto;
      @(posedge clk_sys) disable iff (!rst_n)
      txto_set && !(ctrl_wr && req.wdata[`CIAP_BIT_HALT]) |=> ctrl_q[`CIAP_BIT_TXTO];
   endproperty
   a_txto: assert property (p_txto) else $error("timeout flag missed"); // see R13

   property p_txto_cnt;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(ctrl_q[`CIAP_BIT_TXTO]) |->
         $past(tx_byte) && ($past(txcnt_q) == `CIAP_TXTO_BYTES - 11'h1);
   endproperty
   a_txto_cnt: assert property (p_txto_cnt) else $error("timeout count wrong"); // see R12

   property p_order;
      @(posedge clk_sys) disable iff (!rst_n)
      (state_q == ciap_pkg::CIAP_RUN) |-> $past(state_q) != ciap_pkg::CIAP_IDLE;
   endproperty
   a_order: assert property (p_order) else $error("ring before init"); // see R11

   property p_nohalt_wr;
      @(posedge clk_sys) disable iff (!rst_n)
      (data_wr && idx_q != `CIAP_IDX_CTRL && !rf_ok) |=>
         $stable(u_rf.mem_q[0]) && $stable(u_rf.mem_q[1]) && $stable(u_rf.mem_q[2]);
   endproperty
   a_nohalt_wr: assert property (p_nohalt_wr) else $error("write while running"); // see R06

   // Bus handshake and index port checks
   property p_no_ready;
      @(posedge clk_sys) disable iff (!rst_n)
      !cs |=> !ready;
   endproperty
   a_no_ready: assert property (p_no_ready) else $error("ready without access"); // see R04

   property p_dal_oe;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && rd && !acc_q) |=> dal_oe;
   endproperty
   a_dal_oe: assert property (p_dal_oe) else $error("read not driven"); // see R05

   property p_oe_wr;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && !rd && !acc_q) |=> !dal_oe;
   endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("bus driven on write"); // see R05

   property p_four_regs;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && rd && port_sel && !acc_q) |=> dal_out_q[`CIAP_IDX_W-1:0] == $past(idx_q);
   endproperty
   a_four_regs: assert property (p_four_regs) else $error("index read wrong"); // see R01

   property p_idx_wr_ctrl;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && !rd && port_sel && !acc_q) |=> $stable(ctrl_q[`CIAP_BIT_HALT]);
   endproperty
   a_idx_wr_ctrl: assert property (p_idx_wr_ctrl) else $error("index write leaked"); // see R02

   // Data port and byte counter checks
   property p_ctrl_rd;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && rd && !port_sel && !acc_q && idx_q == `CIAP_IDX_CTRL) |=>
         dal_out_q[`CIAP_BIT_HALT] == $past(ctrl_q[`CIAP_BIT_HALT]);
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("register zero read wrong"); // see R05

   property p_rf_rd;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && rd && !port_sel && !acc_q && idx_q != `CIAP_IDX_CTRL && rf_ok) |=>
         dal_out_q == $past(u_rf.mem_q[idx_q - 2'h1]);
   endproperty
   a_rf_rd: assert property (p_rf_rd) else $error("register read wrong"); // see R05

   property p_nohalt_rd;
      @(posedge clk_sys) disable iff (!rst_n)
      (cs && rd && !port_sel && !acc_q && idx_q != `CIAP_IDX_CTRL && !rf_ok) |=>
         dal_out_q == `CIAP_ZERO16;
   endproperty
   a_nohalt_rd: assert property (p_nohalt_rd) else $error("running read not blanked"); // see R07

   property p_halt_wr;
      @(posedge clk_sys) disable iff (!rst_n)
      (ctrl_wr && req.wdata[`CIAP_BIT_HALT]) |=> ctrl_q == `CIAP_CSR_RESET;
   endproperty
   a_halt_wr: assert property (p_halt_wr) else $error("halt did not reset"); // see R06

   property p_txto_clr;
      @(posedge clk_sys) disable iff (!rst_n)
      (ctrl_wr && req.wdata[`CIAP_BIT_TXTO] && !txto_set) |=> !ctrl_q[`CIAP_BIT_TXTO];
   endproperty
   a_txto_clr: assert property (p_txto_clr) else $error("timeout flag not cleared"); // see R13

   property p_txto_keep;
      @(posedge clk_sys) disable iff (!rst_n)
      (ctrl_wr && !req.wdata[`CIAP_BIT_TXTO] && !req.wdata[`CIAP_BIT_HALT] &&
       ctrl_q[`CIAP_BIT_TXTO]) |=> ctrl_q[`CIAP_BIT_TXTO];
   endproperty
   a_txto_keep: assert property (p_txto_keep) else $error("timeout flag lost"); // see R13

   property p_cnt_clr;
      @(posedge clk_sys) disable iff (!rst_n)
      tx_frame_end |=> txcnt_q == '0;
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("byte count not cleared"); // see R13

   // Engine order checks
   property p_halt_stop;
      @(posedge clk_sys) disable iff (!rst_n)
      halted |=> !fetch_init && !ring_access;
   endproperty
   a_halt_stop: assert property (p_halt_stop) else $error("engine active while halted"); // see R11

   property p_init_go;
      @(posedge clk_sys) disable iff (!rst_n)
      (state_q == ciap_pkg::CIAP_IDLE && ctrl_q[`CIAP_BIT_INIT] && !halted) |=>
         fetch_init;
   endproperty
   a_init_go: assert property (p_init_go) else $error("init fetch not started"); // see R11
endmodule
`default_nettype wire

// *** ciap_host.sv ***
// Host model driving slave cycles of the register access port
`default_nettype none
module ciap_host (
   // Clock
   input  wire logic        clk_sys,
   // Slave bus
   input  wire logic        ready,
   input  wire logic [15:0] dal_out_q,
   output var  logic        cs,
   output var  logic        port_sel,
   output var  logic        rd,
   output var  logic [15:0] dal_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cs = 1'b0;
      port_sel = 1'b0;
      rd = 1'b0;
      dal_in = 16'h0000;
   end
   // One whole slave cycle, held until ready is seen or eight clocks pass
   task automatic xfer(input logic sel, input logic r, input logic [15:0] wd,
                       output logic [15:0] rv, output logic ok);
      int n;
      n = 0;
      @(posedge clk_sys);
      #1;
      cs = 1'b1;
      port_sel = sel;
      rd = r;
      dal_in = wd;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (ready !== 1'b1 && n < 8);
      rv = dal_out_q;
      ok = (ready === 1'b1);
      #1;
      cs = 1'b0;
      // Released lines no longer show the old value
      dal_in = ~wd;
   endtask
endmodule
`default_nettype wire

// *** ciap_top_bench.sv ***
// Self-checking bench for the register access port
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module ciap_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, rst_n, cs, port_sel, rd, dal_oe, ready, ok, oe_seen;
   logic        init_done, tx_byte, tx_frame_end, halted, fetch_init, ring_access, irq;
   logic [15:0] dal_in, dal_out_q, rv;
   int          n_mismatch, n_tests, cyc;
   ciap_top ciap_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .cs(cs), .port_sel(port_sel),
      .rd(rd), .dal_in(dal_in), .dal_out_q(dal_out_q), .dal_oe(dal_oe), .ready(ready),
      .init_done(init_done), .tx_byte(tx_byte), .tx_frame_end(tx_frame_end),
      .halted(halted), .fetch_init(fetch_init), .ring_access(ring_access), .irq(irq));
   ciap_host ciap_host_i (.clk_sys(clk_sys), .ready(ready), .dal_out_q(dal_out_q),
      .cs(cs), .port_sel(port_sel), .rd(rd), .dal_in(dal_in));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic end_sim;
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   // Bus drive seen in the ready cycle
   always @(posedge clk_sys)
      if (ready)
         oe_seen <= dal_oe;
   task automatic acc(input logic s, input logic r, input logic [15:0] w);
      ciap_host_i.xfer(s, r, w, rv, ok);
      `CHK(ok, 1'b1)
      `CHK(oe_seen, r)
   endtask
   // One-cycle event: 0 init done, 1 byte sent, 2 frame end
   task automatic pulse(input int which);
      @(posedge clk_sys);
      #1;
      init_done = (which == 0);
      tx_byte = (which == 1);
      tx_frame_end = (which == 2);
      @(posedge clk_sys);
      #1;
      init_done = 1'b0;
      tx_byte = 1'b0;
      tx_frame_end = 1'b0;
   endtask
   task automatic t_index;
      acc(1'b1, 1'b1, 16'h0000);
      `CHK(rv, 16'h0000)
      acc(1'b1, 1'b0, 16'h0003);
      acc(1'b1, 1'b1, 16'h0000);
      `CHK(rv, 16'h0003)
      acc(1'b1, 1'b0, 16'h0000);
   endtask
   task automatic t_halt;
      acc(1'b0, 1'b0, 16'h0001);
      `CHK(halted, 1'b1)
      acc(1'b1, 1'b0, 16'h0002);
      acc(1'b0, 1'b0, 16'h5a3c);
      acc(1'b0, 1'b1, 16'h0000);
      `CHK(rv, 16'h5a3c)
      acc(1'b1, 1'b0, 16'h0000);
      acc(1'b0, 1'b0, 16'h0004);
      acc(1'b1, 1'b0, 16'h0002);
      acc(1'b0, 1'b1, 16'h0000);
      `CHK(rv, 16'h0000)
      acc(1'b0, 1'b0, 16'h1111);
      acc(1'b1, 1'b0, 16'h0000);
      acc(1'b0, 1'b0, 16'h0001);
      acc(1'b1, 1'b0, 16'h0002);
      acc(1'b0, 1'b1, 16'h0000);
      `CHK(rv, 16'h5a3c)
      acc(1'b1, 1'b0, 16'h0000);
   endtask
   task automatic t_init;
      acc(1'b0, 1'b0, 16'h0006);
      `CHK(fetch_init, 1'b1)
      `CHK(ring_access, 1'b0)
      pulse(0);
      `CHK(ring_access, 1'b1)
      `CHK(fetch_init, 1'b0)
   endtask
   task automatic t_reset;
      acc(1'b1, 1'b0, 16'h0002);
      @(posedge clk_sys);
      #1 rst_n = 1'b0;
      @(posedge clk_sys);
      #1 rst_n = 1'b1;
      `CHK(halted, 1'b1)
      acc(1'b1, 1'b1, 16'h0000);
      `CHK(rv, 16'h0000)
   endtask
   task automatic t_timeout;
      acc(1'b0, 1'b0, 16'h0044);
      repeat (1518) pulse(1);
      acc(1'b0, 1'b1, 16'h0000);
      `CHK(rv[14], 1'b0)
      pulse(1);
      acc(1'b0, 1'b1, 16'h0000);
      `CHK(rv[15:14], 2'h3)
      `CHK(irq, 1'b1)
      pulse(2);
      acc(1'b0, 1'b0, 16'h4044);
      acc(1'b0, 1'b1, 16'h0000);
      `CHK(rv[14], 1'b0)
   endtask
   initial
   begin
      n_mismatch = 0;
      n_tests = 0;
      cyc = 0;
      rst_n = 1'b0;
      init_done = 1'b0;
      tx_byte = 1'b0;
      tx_frame_end = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      t_index();
      t_halt();
      t_init();
      t_timeout();
      t_reset();
      end_sim();
   end
endmodule
`default_nettype wire
